// file: core/scrb_bank.v
`timescale 1ns/1ns
`default_nettype none
`include "scrb_defines.vh"
module scrb_bank #(
    parameter CYC_PER_MS = `SCRB_CYC_PER_MS
) (
    // Clock, reset, enable
    input wire clk,
    input wire reset,
    input wire ce,
    // SPI pins, mode 0
    input wire spi_clk,
    input wire spi_cs_n,
    input wire spi_di,
    output wire spi_do,
    output wire spi_do_oe,
    // Motion pins
    input wire step_pulse_pin,
    input wire dir_pin,
    // Translator and driver controls
    output reg step_advance,
    output reg rotate_ccw,
    output reg [2:0] step_mode_select,
    output reg [4:0] coil_current_level,
    output reg [1:0] slope_select,
    output reg pwm_double,
    output reg pwm_jitter,
    output reg driver_enable,
    output reg sleep_mode,
    output reg speed_angle_gain_quarter,
    output reg speed_angle_transparent,
    // Status
    output reg watchdog_event_flag
);
    ////////////////////////////////////////////////////////////////////////
    wire sclk_s;
    wire cs_n_s;
    wire di_s;
    wire step_s;
    wire dir_s;
    // Chip select idles high; a low reset value would drive data out during reset
    scrb_sync #(.WIDTH(5), .RESET_VAL(5'h08)) u_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in({spi_clk, spi_cs_n, spi_di, step_pulse_pin, dir_pin}),
        .sync_out({sclk_s, cs_n_s, di_s, step_s, dir_s})
    );
    reg sclk_d_ff;
    reg cs_d_ff;
    reg step_d_ff;
    wire sclk_rise = sclk_s && !sclk_d_ff;
    wire sclk_fall = !sclk_s && sclk_d_ff;
    wire cs_rise = cs_n_s && !cs_d_ff;
    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] wd_ctrl_ff;
    reg [7:0] step_ctrl_ff;
    reg [7:0] opt_ctrl_ff;
    reg [7:0] en_ctrl_ff;
    reg wd_flag_ff;
    // SPI engine
    reg [7:0] shin_ff;
    reg [7:0] shout_ff;
    reg [5:0] bitcnt_ff;
    reg [7:0] cmd_ff;
    reg [4:0] last_addr_ff;
    reg [7:0] wdata_ff;
    wire [7:0] nxt_shin = {shin_ff[6:0], di_s};
    wire timeout;
    function [7:0] rd_mux;
        input [4:0] addr;
        begin
            case (addr)
                `SCRB_ADDR_WD: rd_mux = wd_ctrl_ff & `SCRB_WD_MASK;
                `SCRB_ADDR_STEP: rd_mux = step_ctrl_ff;
                `SCRB_ADDR_OPT: rd_mux = opt_ctrl_ff & `SCRB_OPT_MASK;
                `SCRB_ADDR_EN: rd_mux = en_ctrl_ff & `SCRB_EN_MASK;
                `SCRB_ADDR_SR0: rd_mux = {1'b0, 2'h0, wd_flag_ff, 4'h0} ^ {wd_flag_ff, 7'h00};
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction
    // Commit only on deselect and exactly two bytes of a write
    wire commit = cs_rise && (bitcnt_ff == `SCRB_XFER_BITS) && (cmd_ff[7:5] == `SCRB_CMD_WRITE);
    wire [4:0] waddr = cmd_ff[4:0];
    wire wd_wr = commit && (waddr == `SCRB_ADDR_WD);
    wire wr_en1 = wd_wr && wdata_ff[`SCRB_WD_EN_BIT];
    wire wr_en0 = wd_wr && !wdata_ff[`SCRB_WD_EN_BIT];
    scrb_watchdog #(.CYC_PER_MS(CYC_PER_MS)) u_wd (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_en1(wr_en1),
        .wr_en0(wr_en0),
        // Stored field, as the shift data changes with every later frame
        .interval_sel(wd_ctrl_ff[6:3]),
        .timeout(timeout)
    );
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            step_d_ff <= 1'b0;
            shin_ff <= 8'h00;
            shout_ff <= 8'h00;
            bitcnt_ff <= 6'h00;
            cmd_ff <= 8'h00;
            last_addr_ff <= 5'h00;
            wdata_ff <= 8'h00;
        end else if (ce) begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_n_s;
            step_d_ff <= step_s;
            if (cs_n_s) begin
                bitcnt_ff <= 6'h00;
            end else begin
                if (sclk_rise) begin
                    shin_ff <= nxt_shin;
                    if (bitcnt_ff != 6'h3f) begin
                        bitcnt_ff <= bitcnt_ff + 6'h01;
                    end
                    if (bitcnt_ff == 6'h07) begin
                        cmd_ff <= nxt_shin;
                    end
                    if (bitcnt_ff == 6'h0f) begin
                        wdata_ff <= nxt_shin;
                    end
                end
                if (sclk_fall) begin
                    if (bitcnt_ff[2:0] == 3'h0 && bitcnt_ff != 6'h00) begin
                        // Byte boundary: load addressed register, MSB first
                        shout_ff <= rd_mux(shin_ff[4:0]);
                        last_addr_ff <= shin_ff[4:0];
                    end else begin
                        shout_ff <= {shout_ff[6:0], 1'b0};
                    end
                end
            end
        end
    end
    assign spi_do = shout_ff[7];
    assign spi_do_oe = !cs_n_s;
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wd_ctrl_ff <= `SCRB_RESET_VAL;
            step_ctrl_ff <= `SCRB_RESET_VAL;
            opt_ctrl_ff <= `SCRB_RESET_VAL;
            en_ctrl_ff <= `SCRB_RESET_VAL;
            wd_flag_ff <= 1'b0;
        end else if (ce) begin
            if (commit) begin
                case (waddr)
                    `SCRB_ADDR_WD: wd_ctrl_ff <= wdata_ff & `SCRB_WD_MASK;
                    `SCRB_ADDR_STEP: step_ctrl_ff <= wdata_ff;
                    `SCRB_ADDR_OPT: opt_ctrl_ff <= wdata_ff & `SCRB_OPT_MASK;
                    `SCRB_ADDR_EN: en_ctrl_ff <= wdata_ff & `SCRB_EN_MASK;
                    default: wd_ctrl_ff <= wd_ctrl_ff;
                endcase
            end
            // Timeout set wins over the clear by an enable-0 write
            if (timeout) begin
                wd_flag_ff <= 1'b1;
            end else if (wr_en0) begin
                wd_flag_ff <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Outputs decoded from registers, all registered
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            step_advance <= 1'b0;
            rotate_ccw <= 1'b0;
            step_mode_select <= 3'h0;
            coil_current_level <= 5'h00;
            slope_select <= 2'h0;
            pwm_double <= 1'b0;
            pwm_jitter <= 1'b0;
            driver_enable <= 1'b0;
            sleep_mode <= 1'b0;
            speed_angle_gain_quarter <= 1'b0;
            speed_angle_transparent <= 1'b0;
            watchdog_event_flag <= 1'b0;
        end else if (ce) begin
            // Sleep ignores step input; edge polarity chosen by option bit
            step_advance <= !en_ctrl_ff[6] && (opt_ctrl_ff[6] ? (!step_s && step_d_ff)
                                                              : (step_s && !step_d_ff));
            if (!en_ctrl_ff[6]) begin
                rotate_ccw <= dir_s ^ opt_ctrl_ff[7];
            end
            step_mode_select <= step_ctrl_ff[7:5];
            coil_current_level <= step_ctrl_ff[4:0];
            slope_select <= opt_ctrl_ff[1:0];
            pwm_double <= opt_ctrl_ff[3];
            pwm_jitter <= opt_ctrl_ff[2];
            driver_enable <= en_ctrl_ff[7] && !en_ctrl_ff[6];
            sleep_mode <= en_ctrl_ff[6];
            speed_angle_gain_quarter <= en_ctrl_ff[5];
            speed_angle_transparent <= en_ctrl_ff[4];
            watchdog_event_flag <= wd_flag_ff;
        end
    end
endmodule // scrb_bank
`default_nettype wire

// file: core/scrb_defines.vh
`ifndef SCRB_DEFINES_VH
`define SCRB_DEFINES_VH
`define SCRB_ADDR_WD 5'h00
`define SCRB_ADDR_STEP 5'h01
`define SCRB_ADDR_OPT 5'h02
`define SCRB_ADDR_EN 5'h03
`define SCRB_ADDR_SR0 5'h04
`define SCRB_CMD_READ 3'h0
`define SCRB_CMD_WRITE 3'h4
`define SCRB_RESET_VAL 8'h00
`define SCRB_WD_EN_BIT 7
`define SCRB_WD_MASK 8'hf8
`define SCRB_OPT_MASK 8'hcf
`define SCRB_EN_MASK 8'hf0
`define SCRB_SR0_WD_BIT 4
`define SCRB_XFER_BITS 16
`define SCRB_WD_STEP_MS 32
`define SCRB_CLK_HZ 25000000
`define SCRB_CYC_PER_MS (`SCRB_CLK_HZ / 1000)
`endif

// file: core/scrb_sync.v
`timescale 1ns/1ns
`default_nettype none
module scrb_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    input wire ce,
    // Asynchronous levels in, synchronised out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            // Idle level of each pin, so no false edge follows reset
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else if (ce) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule // scrb_sync
`default_nettype wire

// file: core/scrb_watchdog.v
`timescale 1ns/1ns
`default_nettype none
`include "scrb_defines.vh"
module scrb_watchdog #(
    parameter CYC_PER_MS = `SCRB_CYC_PER_MS
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    input wire ce,
    // Control from register bank
    input wire wr_en1,
    input wire wr_en0,
    input wire [3:0] interval_sel,
    // Timeout event, one cycle
    output wire timeout
);
    reg running_ff;
    reg [31:0] cyc_ff;
    reg [9:0] ms_ff;
    reg [31:0] nxt_cyc;
    wire [9:0] limit_ms;
    wire [31:0] limit_full;
    wire ms_tick;
    // Period in ms is 32 * (sel + 1); the largest value fits ten bits
    assign limit_full = `SCRB_WD_STEP_MS * ({28'h0000000, interval_sel} + 32'h00000001);
    assign limit_ms = limit_full[9:0];
    assign ms_tick = (cyc_ff == CYC_PER_MS - 1);
    assign timeout = running_ff && ms_tick && (ms_ff == limit_ms - 10'h001);
    always @* begin
        nxt_cyc = ms_tick ? 32'h00000000 : cyc_ff + 32'h00000001;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            running_ff <= 1'b0;
            cyc_ff <= 32'h00000000;
            ms_ff <= 10'h000;
        end else if (ce) begin
            if (wr_en0) begin
                running_ff <= 1'b0;
                cyc_ff <= 32'h00000000;
                ms_ff <= 10'h000;
            end else if (wr_en1) begin
                running_ff <= 1'b1;
                cyc_ff <= 32'h00000000;
                ms_ff <= 10'h000;
            end else if (running_ff) begin
                cyc_ff <= nxt_cyc;
                if (timeout) begin
                    // Keeps running so a silent master keeps being flagged
                    ms_ff <= 10'h000;
                end else if (ms_tick) begin
                    ms_ff <= ms_ff + 10'h001;
                end
            end
        end
    end
endmodule // scrb_watchdog
`default_nettype wire

// file: verif/scrb_bank_chk.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_bank_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Pins
    input wire logic spi_cs_n,
    input wire logic spi_do_oe,
    input wire logic step_pulse_pin,
    input wire logic dir_pin,
    // Controls
    input wire logic step_advance,
    input wire logic rotate_ccw,
    input wire logic [2:0] step_mode_select,
    input wire logic [4:0] coil_current_level,
    input wire logic [1:0] slope_select,
    input wire logic driver_enable,
    input wire logic sleep_mode,
    input wire logic watchdog_event_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clear: assert property (
        $fell(reset) |-> !driver_enable && !sleep_mode && !watchdog_event_flag && step_mode_select == 3'h0)
        else $error("outputs not clear after reset");
    a_sleep_step: assert property (sleep_mode |-> !step_advance) else $error("step in sleep");
    a_sleep_drv: assert property (sleep_mode |-> !driver_enable) else $error("driver on in sleep");
    // Writes land a few cycles after deselect, so a long select must see no change
    a_cfg_stable: assert property (
        (!spi_cs_n)[*8] |-> $stable({step_mode_select, coil_current_level, slope_select, driver_enable, sleep_mode}))
        else $error("config changed inside frame");
    a_oe_on: assert property ((!spi_cs_n)[*3] |-> spi_do_oe) else $error("data out not driven");
    a_oe_off: assert property (spi_cs_n[*3] |-> !spi_do_oe) else $error("data out driven idle");
    a_step_single: assert property (step_advance |=> !step_advance) else $error("step too wide");
    a_step_idle: assert property ($stable(step_pulse_pin)[*8] |-> !step_advance) else $error("step no edge");
    a_dir_hold: assert property (($stable(dir_pin) && spi_cs_n)[*8] |-> $stable(rotate_ccw))
        else $error("direction moved");
endmodule // scrb_bank_chk
`default_nettype wire

// file: verif/scrb_master.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_master (
    // System clock
    input wire logic clk,
    // SPI pins
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_di,
    input wire logic spi_do
);
    logic [15:0] rx = 16'h0000;
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_di = 1'b0;
    end
    // Mode 0, five system clocks low and four high per bit; sends tx[31] down to tx[32-n]
    task automatic xfer(input int n, input logic [31:0] tx);
        @(posedge clk) spi_cs_n <= 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            @(posedge clk) spi_di <= tx[i];
            repeat (4) @(posedge clk);
            spi_clk <= 1'b1;
            rx = {rx[14:0], spi_do};
            repeat (4) @(posedge clk);
            spi_clk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        spi_cs_n <= 1'b1;
        // Nothing holds the data line after the frame
        spi_di <= ~spi_di;
        repeat (8) @(posedge clk);
    endtask
endmodule // scrb_master
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic step_pulse_pin = 1'b0;
    logic dir_pin = 1'b0;
    logic spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe, step_advance, rotate_ccw, pwm_double, pwm_jitter;
    logic driver_enable, sleep_mode, gain_q, transp, watchdog_event_flag;
    logic [2:0] step_mode_select;
    logic [4:0] coil_current_level;
    logic [1:0] slope_select;
    wire logic do_w = spi_do_oe ? spi_do : 1'b1;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    int steps = 0;
    logic [7:0] ex [8] = '{default: 8'h00};
    logic [7:0] msk [4] = '{8'hf8, 8'hff, 8'hcf, 8'hf0};
    logic [31:0] r;
    always #20 clk = ~clk;
    scrb_master m (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_di(spi_di), .spi_do(do_w));
    scrb_bank #(.CYC_PER_MS(8)) DUT (.clk(clk), .reset(reset), .ce(1'b1), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_di(spi_di), .spi_do(spi_do), .spi_do_oe(spi_do_oe),
        .step_pulse_pin(step_pulse_pin), .dir_pin(dir_pin), .step_advance(step_advance), .rotate_ccw(rotate_ccw),
        .step_mode_select(step_mode_select), .coil_current_level(coil_current_level), .slope_select(slope_select),
        .pwm_double(pwm_double), .pwm_jitter(pwm_jitter), .driver_enable(driver_enable), .sleep_mode(sleep_mode),
        .speed_angle_gain_quarter(gain_q), .speed_angle_transparent(transp), .watchdog_event_flag(watchdog_event_flag));
    ////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input int n, input logic [2:0] c, input logic [4:0] a, input logic [7:0] d);
        m.xfer(n, {c, a, d, 16'h0000});
        if (n == 16 && c == 3'h4 && a < 5'h04) ex[a] = d & msk[a[1:0]];
    endtask
    task automatic rd(input logic [4:0] a);
        m.xfer(16, {3'h0, a, 24'h000000});
        chk(m.rx[7:0], ex[a]);
    endtask
    task automatic outs;
        chk({step_mode_select, coil_current_level}, ex[1]);
        chk({rotate_ccw, 3'h0, pwm_double, pwm_jitter, slope_select}, {dir_pin ^ ex[2][7], 3'h0, ex[2][3:0]});
        chk({driver_enable, sleep_mode, gain_q, transp, 4'h0}, {ex[3][7] & ~ex[3][6], ex[3][6:4], 4'h0});
    endtask
    task automatic stp(input logic [7:0] e1, input logic [7:0] e2);
        int s;
        s = steps;
        step_pulse_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk(8'(steps - s), e1);
        step_pulse_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk(8'(steps - s), e2);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (step_advance === 1'b1) steps++;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(87));
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 8; a++) rd(a[4:0]);
        // Sleep kept out here: it freezes direction and is tested on its own
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            dir_pin <= r[16];
            wr(16, 3'h4, 5'h01, {i[2:0], r[4:0]});
            wr(16, 3'h4, 5'h02, {r[15:10], i[1:0]});
            wr(16, 3'h4, 5'h03, {r[27], 1'b0, r[25:20]});
            outs();
            for (int a = 0; a < 4; a++) rd(a[4:0]);
        end
        wr(15, 3'h4, 5'h01, 8'h5a);
        wr(17, 3'h4, 5'h02, 8'h5a);
        wr(16, 3'h0, 5'h03, 8'h5a);
        wr(16, 3'h4, 5'h04, 8'h5a);
        for (int a = 0; a < 8; a++) rd(a[4:0]);
        wr(16, 3'h4, 5'h03, 8'h80);
        wr(16, 3'h4, 5'h02, 8'h00);
        stp(8'h01, 8'h01);
        wr(16, 3'h4, 5'h02, 8'h40);
        stp(8'h00, 8'h01);
        wr(16, 3'h4, 5'h03, 8'hc0);
        outs();
        // Direction moves in sleep; the held sense must not follow it
        dir_pin <= ~dir_pin;
        stp(8'h00, 8'h00);
        chk({7'h0, rotate_ccw}, {7'h0, ~dir_pin ^ ex[2][7]});
        wr(16, 3'h4, 5'h03, 8'h80);
        rd(5'h02);
        wr(16, 3'h4, 5'h00, 8'h88);
        repeat (490) @(posedge clk);
        chk({7'h0, watchdog_event_flag}, 8'h00);
        repeat (40) @(posedge clk);
        chk({7'h0, watchdog_event_flag}, 8'h01);
        ex[4] = 8'h90;
        rd(5'h04);
        wr(16, 3'h4, 5'h00, 8'h00);
        ex[4] = 8'h00;
        chk({7'h0, watchdog_event_flag}, 8'h00);
        repeat (600) @(posedge clk);
        rd(5'h04);
        wr(16, 3'h4, 5'h00, 8'h88);
        repeat (300) @(posedge clk);
        wr(16, 3'h4, 5'h00, 8'h88);
        repeat (400) @(posedge clk);
        chk({7'h0, watchdog_event_flag}, 8'h00);
        repeat (150) @(posedge clk);
        chk({7'h0, watchdog_event_flag}, 8'h01);
        rd(5'h00);
        final_report();
    end
endmodule // tb
bind scrb_bank scrb_bank_chk chk_i (.clk(clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_do_oe(spi_do_oe),
    .step_pulse_pin(step_pulse_pin), .dir_pin(dir_pin), .step_advance(step_advance), .rotate_ccw(rotate_ccw),
    .step_mode_select(step_mode_select), .coil_current_level(coil_current_level), .slope_select(slope_select),
    .driver_enable(driver_enable), .sleep_mode(sleep_mode), .watchdog_event_flag(watchdog_event_flag));
`default_nettype wire
